// ---- hdl/pld_lock_div.sv ----
// Lock detector, divider selection and pump code with AHB-Lite registers
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module pld_lock_div
  import pld_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output wire logic hreadyout,
  output wire logic hresp,
  input wire logic ref_in,
  input wire logic osc_in,
  output wire logic fb_clk,
  output wire logic [4:0] out_clk,
  output logic pll_lock,
  output logic [3:0] pump_current_sel,
  output logic pump_hiz,
  output logic [11:0] pump_current_ua,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] lock_window_sel;
  logic [1:0] lock_count_sel;
  logic [2:0] feedback_div_sel;
  logic [1:0] pwd_sel;
  logic [14:0] output_div_sel;
  logic [1:0] quad_sel;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic dp_write;
  logic [7:0] dp_addr;
  logic osc_level;
  logic osc_d;
  logic ref_level;
  logic ref_d;
  logic fb_d;
  pld_cmp_type cmp_state;
  pld_cmp_type next_cmp_state;
  logic [7:0] wcnt;
  logic [7:0] next_wcnt;
  logic hit;
  logic miss;
  logic [8:0] lock_cnt;
  logic [15:0] ref_per_cnt;
  logic [15:0] fb_per_cnt;
  logic [15:0] fb_period;
  logic ref_seen;
  logic fb_seen;
  logic fb_valid;

  // ----------------------------------------------------------------
  // Pin synchronisers and oscillator edges
  // ----------------------------------------------------------------
  pld_sync2 u_osc_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(osc_in),
    .q(osc_level)
  );

  pld_sync2 u_ref_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(ref_in),
    .q(ref_level)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_d <= 1'b0;
      ref_d <= 1'b0;
      fb_d <= 1'b0;
    end else begin
      osc_d <= osc_level;
      ref_d <= ref_level;
      fb_d <= fb_clk;
    end
  end

  wire osc_tick = osc_level & ~osc_d;
  wire ref_edge = ref_level & ~ref_d;
  wire fb_edge = fb_clk & ~fb_d;

  // ----------------------------------------------------------------
  // Feedback and output dividers
  // ----------------------------------------------------------------
  pld_divider u_fb_div (
    .clk(clk),
    .rst_n(rst_n),
    .osc_tick(osc_tick),
    .osc_level(osc_level),
    .div_sel(feedback_div_sel),
    .quad_sel(quad_sel),
    .div_out(fb_clk)
  );

  for (genvar i = 0; i < 5; i++) begin : g_out
    pld_divider u_out_div (
      .clk(clk),
      .rst_n(rst_n),
      .osc_tick(osc_tick),
      .osc_level(osc_level),
      .div_sel(output_div_sel[3*i +: 3]),
      .quad_sel(quad_sel),
      .div_out(out_clk[i])
    );
  end

  // ----------------------------------------------------------------
  // Window, count and resolution decode
  // ----------------------------------------------------------------
  wire freq_mode = lock_window_sel == WIN_FREQ_CODE;
  wire [7:0] win_cyc = (lock_window_sel == 2'h0) ? WIN_NARROW_CYC :
    (lock_window_sel == 2'h1) ? WIN_MID_CYC : WIN_WIDE_CYC;
  wire [8:0] need_cnt = (lock_count_sel == 2'h0) ? LOCK_NEED_0 :
    (lock_count_sel == 2'h1) ? LOCK_NEED_1 :
    (lock_count_sel == 2'h2) ? LOCK_NEED_2 : LOCK_NEED_3;
  wire [15:0] pwd_cyc = (pwd_sel == 2'h0) ? PWD_0_CYC :
    (pwd_sel == 2'h1) ? PWD_1_CYC :
    (pwd_sel == 2'h2) ? PWD_2_CYC : PWD_3_CYC;
  wire timeout = !freq_mode && (wcnt >= win_cyc);

  // ----------------------------------------------------------------
  // Edge pairing
  // ----------------------------------------------------------------
  always_comb begin
    next_cmp_state = cmp_state;
    next_wcnt = (wcnt == 8'hff) ? wcnt : wcnt + 8'h01;
    hit = 1'b0;
    miss = 1'b0;
    unique case (cmp_state)
      CMP_IDLE: begin
        next_wcnt = 8'h00;
        if (ref_edge && fb_edge) begin
          hit = 1'b1;
        end else if (ref_edge) begin
          next_cmp_state = CMP_REF_FIRST;
        end else if (fb_edge) begin
          next_cmp_state = CMP_FB_FIRST;
        end
      end
      CMP_REF_FIRST: begin
        if (fb_edge) begin
          hit = 1'b1;
          next_cmp_state = CMP_IDLE;
        end else if (ref_edge || timeout) begin
          miss = 1'b1;
          next_wcnt = 8'h00;
          next_cmp_state = ref_edge ? CMP_REF_FIRST : CMP_IDLE;
        end
      end
      CMP_FB_FIRST: begin
        if (ref_edge) begin
          hit = 1'b1;
          next_cmp_state = CMP_IDLE;
        end else if (fb_edge || timeout) begin
          miss = 1'b1;
          next_wcnt = 8'h00;
          next_cmp_state = fb_edge ? CMP_FB_FIRST : CMP_IDLE;
        end
      end
      default: begin
        next_cmp_state = CMP_IDLE;
        next_wcnt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_state <= CMP_IDLE;
      wcnt <= 8'h00;
    end else begin
      cmp_state <= next_cmp_state;
      wcnt <= next_wcnt;
    end
  end

  // ----------------------------------------------------------------
  // Period measurement for frequency offset
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_per_cnt <= 16'h0000;
      fb_per_cnt <= 16'h0000;
      fb_period <= 16'h0000;
      ref_seen <= 1'b0;
      fb_seen <= 1'b0;
      fb_valid <= 1'b0;
    end else begin
      if (ref_edge) begin
        ref_per_cnt <= 16'h0001;
        ref_seen <= 1'b1;
      end else if (ref_per_cnt != 16'hffff) begin
        ref_per_cnt <= ref_per_cnt + 16'h0001;
      end
      if (fb_edge) begin
        fb_per_cnt <= 16'h0001;
        fb_period <= fb_per_cnt;
        fb_seen <= 1'b1;
        fb_valid <= fb_seen;
      end else if (fb_per_cnt != 16'hffff) begin
        fb_per_cnt <= fb_per_cnt + 16'h0001;
      end
    end
  end

  // Periods differing by more than the pulse width delay are resolvable
  wire [15:0] per_diff = (ref_per_cnt > fb_period) ? ref_per_cnt - fb_period :
    fb_period - ref_per_cnt;
  wire offset_det = freq_mode && ref_edge && ref_seen && fb_valid &&
    (per_diff > pwd_cyc);

  // ----------------------------------------------------------------
  // Lock counter and indicator
  // ----------------------------------------------------------------
  wire lose = miss | offset_det;
  wire [8:0] cnt_inc = (lock_cnt < need_cnt) ? lock_cnt + 9'h001 : lock_cnt;
  wire [8:0] next_lock_cnt = lose ? 9'h000 : hit ? cnt_inc : lock_cnt;
  wire next_lock = lose ? 1'b0 :
    (hit && (cnt_inc >= need_cnt)) ? 1'b1 : pll_lock;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_cnt <= 9'h000;
      pll_lock <= 1'b0;
    end else begin
      lock_cnt <= next_lock_cnt;
      pll_lock <= next_lock;
    end
  end

  // ----------------------------------------------------------------
  // Charge pump code
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pump_hiz <= 1'b0;
      pump_current_ua <= 12'h000;
    end else begin
      pump_hiz <= pump_current_sel == 4'h0;
      pump_current_ua <= 12'(pump_current_sel * PUMP_STEP_UA);
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire ahb_take = hsel && hready && htrans[1] && (hsize == 3'h2);
  wire wr_lock = dp_write && dp_addr == OFS_LOCK_CTRL;
  wire wr_pump = dp_write && dp_addr == OFS_PUMP;
  wire wr_fb = dp_write && dp_addr == OFS_FB_DIV;
  wire wr_out = dp_write && dp_addr == OFS_OUT_DIV;
  wire wr_mode = dp_write && dp_addr == OFS_WORD1_MODE;
  wire wr_clr = dp_write && dp_addr == OFS_IRQ_CLEAR;
  wire wr_en = dp_write && dp_addr == OFS_IRQ_ENABLE;
  wire [2:0] irq_event;
  assign irq_event[IRQ_LOCK_BIT] = next_lock & ~pll_lock;
  assign irq_event[IRQ_LOSS_BIT] = ~next_lock & pll_lock;
  assign irq_event[IRQ_FOFS_BIT] = offset_det;
  wire [2:0] clr_mask = wr_clr ? hwdata[2:0] : 3'h0;

  wire [31:0] rd_lock = 32'({lock_count_sel, 2'b00, lock_window_sel});
  wire [31:0] rd_fb = 32'({pwd_sel, 1'b0, feedback_div_sel});
  wire [31:0] rd_mode = {quad_sel, 30'h0};
  wire [31:0] rd_stat = 32'({lock_cnt, 7'h00, pll_lock});
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_mux = (ra == OFS_LOCK_CTRL) ? rd_lock :
    (ra == OFS_PUMP) ? 32'(pump_current_sel) :
    (ra == OFS_FB_DIV) ? rd_fb :
    (ra == OFS_OUT_DIV) ? 32'(output_div_sel) :
    (ra == OFS_WORD1_MODE) ? rd_mode :
    (ra == OFS_STATUS) ? rd_stat :
    (ra == OFS_IRQ_STATUS) ? 32'(irq_status) :
    (ra == OFS_IRQ_ENABLE) ? 32'(irq_enable) : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      dp_write <= ahb_take && hwrite;
      dp_addr <= haddr[7:0];
      if (ahb_take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_window_sel <= WIN_SEL_RST;
      lock_count_sel <= CNT_SEL_RST;
      pump_current_sel <= PUMP_RST;
      feedback_div_sel <= FB_DIV_RST;
      pwd_sel <= PWD_RST;
      output_div_sel <= OUT_DIV_RST;
      quad_sel <= QUAD_RST;
      irq_enable <= 3'h0;
    end else begin
      if (wr_lock) begin
        lock_window_sel <= hwdata[WIN_SEL_POS +: 2];
        lock_count_sel <= hwdata[CNT_SEL_POS +: 2];
      end
      if (wr_pump) begin
        pump_current_sel <= hwdata[3:0];
      end
      if (wr_fb) begin
        feedback_div_sel <= hwdata[2:0];
        pwd_sel <= hwdata[PWD_POS +: 2];
      end
      if (wr_out) begin
        output_div_sel <= hwdata[14:0];
      end
      if (wr_mode) begin
        quad_sel <= {hwdata[QUAD8_POS], hwdata[QUAD4_POS]};
      end
      if (wr_en) begin
        irq_enable <= hwdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~clr_mask) | irq_event;
      irq <= |(((irq_status & ~clr_mask) | irq_event) & irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  win_timeout_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      cmp_state == CMP_REF_FIRST && !fb_edge && !freq_mode && wcnt >= win_cyc
      |=> !pll_lock && lock_cnt == 9'h000)
    else $error("late partner edge did not break lock");

  fofs_drop_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      freq_mode && offset_det |=> !pll_lock && irq_status[IRQ_FOFS_BIT] &&
        (irq_status[IRQ_LOSS_BIT] || !$past(pll_lock)))
    else $error("frequency offset did not drop lock");

  fofs_res_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      offset_det |-> per_diff > pwd_cyc && freq_mode)
    else $error("offset flagged below resolution");

  lock_need_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      $rose(pll_lock) |-> lock_cnt >= need_cnt)
    else $error("lock asserted before required count");

  fast_loss_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      miss |=> !pll_lock)
    else $error("lock loss was delayed");

  pump_map_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      $stable(pump_current_sel) |=> pump_current_ua ==
        12'($past(pump_current_sel) * 12'h0c8) &&
        pump_hiz == ($past(pump_current_sel) == 4'h0))
    else $error("pump current does not match code");

  reset_dflt_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> output_div_sel == 15'h5b6d && feedback_div_sel == 3'h5 &&
        lock_window_sel == 2'h1 && lock_count_sel == 2'h2 && quad_sel == 2'h0)
    else $error("configuration defaults wrong after reset");

  cnt_restart_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      lose |=> lock_cnt == 9'h000 && !pll_lock)
    else $error("lock counter did not restart on miss");
endmodule

// ---- hdl/pld_pkg.sv ----
// Constants and types for the PLL lock detect and divider select block
// Operation
// - Window code picks 3.5, 8.5, 18.5 ns, frequency
// - Frequency mode drops lock on detected offset
// - Offset resolution set by pulse width delay
// - Count code needs 1, 16, 64, 256 hits
// - Lock loss is immediate, never counted
// - Pump code: 0 high impedance, 200 uA steps
// - Feedback select routes 1,2,3,4,6,8,16,8 division
// - Five output selects, same map, default 8
// - Word one bits 30/31 turn 16 into quadrature
package pld_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 20000;

  // Longest time in whole cycles, never below one
  function automatic int pld_floor_cyc(input int ps);
    int c;
    c = ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WIN_NARROW_PS = 3500;
  localparam int WIN_MID_PS = 8500;
  localparam int WIN_WIDE_PS = 18500;
  localparam logic [7:0] WIN_NARROW_CYC = 8'(pld_floor_cyc(WIN_NARROW_PS));
  localparam logic [7:0] WIN_MID_CYC = 8'(pld_floor_cyc(WIN_MID_PS));
  localparam logic [7:0] WIN_WIDE_CYC = 8'(pld_floor_cyc(WIN_WIDE_PS));

  localparam int PWD_0_PS = 1500;
  localparam int PWD_1_PS = 3000;
  localparam int PWD_2_PS = 4500;
  localparam int PWD_3_PS = 6000;
  localparam logic [15:0] PWD_0_CYC = 16'(pld_floor_cyc(PWD_0_PS));
  localparam logic [15:0] PWD_1_CYC = 16'(pld_floor_cyc(PWD_1_PS));
  localparam logic [15:0] PWD_2_CYC = 16'(pld_floor_cyc(PWD_2_PS));
  localparam logic [15:0] PWD_3_CYC = 16'(pld_floor_cyc(PWD_3_PS));

  // ----------------------------------------------------------------
  // Codes and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] WIN_FREQ_CODE = 2'h3;
  localparam logic [8:0] LOCK_NEED_0 = 9'h001;
  localparam logic [8:0] LOCK_NEED_1 = 9'h010;
  localparam logic [8:0] LOCK_NEED_2 = 9'h040;
  localparam logic [8:0] LOCK_NEED_3 = 9'h100;
  localparam logic [11:0] PUMP_STEP_UA = 12'h0c8;
  localparam logic [2:0] DIV16_CODE = 3'h6;
  localparam logic [4:0] DIV_TABLE [8] = '{5'h01, 5'h02, 5'h03, 5'h04,
                                          5'h06, 5'h08, 5'h10, 5'h08};
  localparam logic [4:0] QUAD4_RATIO = 5'h04;
  localparam logic [4:0] QUAD8_RATIO = 5'h08;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LOCK_CTRL = 8'h00;
  localparam logic [7:0] OFS_PUMP = 8'h04;
  localparam logic [7:0] OFS_FB_DIV = 8'h08;
  localparam logic [7:0] OFS_OUT_DIV = 8'h0c;
  localparam logic [7:0] OFS_WORD1_MODE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;

  localparam int WIN_SEL_POS = 0;
  localparam int CNT_SEL_POS = 4;
  localparam int PWD_POS = 4;
  localparam int QUAD4_POS = 30;
  localparam int QUAD8_POS = 31;
  localparam int STAT_CNT_POS = 8;
  localparam int IRQ_LOCK_BIT = 0;
  localparam int IRQ_LOSS_BIT = 1;
  localparam int IRQ_FOFS_BIT = 2;

  localparam logic [1:0] WIN_SEL_RST = 2'h1;
  localparam logic [1:0] CNT_SEL_RST = 2'h2;
  localparam logic [3:0] PUMP_RST = 4'ha;
  localparam logic [1:0] PWD_RST = 2'h0;
  localparam logic [2:0] FB_DIV_RST = 3'h5;
  localparam logic [14:0] OUT_DIV_RST = 15'h5b6d;
  localparam logic [1:0] QUAD_RST = 2'h0;

  typedef enum logic [1:0] {
    CMP_IDLE = 2'b00,
    CMP_REF_FIRST = 2'b01,
    CMP_FB_FIRST = 2'b10
  } pld_cmp_type;

endpackage

// ---- hdl/pld_sync2.sv ----
// Two-stage synchroniser for a pin level
`timescale 1ns/10ps
module pld_sync2
  import pld_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ---- hdl/pld_divider.sv ----
// Oscillator divider with selectable ratio and quadrature slot
`timescale 1ns/10ps
module pld_divider
  import pld_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_tick,
  input wire logic osc_level,
  input wire logic [2:0] div_sel,
  input wire logic [1:0] quad_sel,
  output logic div_out
);
  logic [4:0] cnt;

  // ----------------------------------------------------------------
  // Ratio and phase decode
  // ----------------------------------------------------------------
  wire is_div16 = div_sel == DIV16_CODE;
  wire quad = is_div16 & (quad_sel != 2'h0);
  wire [4:0] ratio = !is_div16 ? DIV_TABLE[div_sel] :
    quad_sel[0] ? QUAD4_RATIO :
    quad_sel[1] ? QUAD8_RATIO : DIV_TABLE[div_sel];
  wire [4:0] shift = quad ? {2'b00, ratio[4:2]} : 5'h00;
  wire [4:0] wrapped = cnt + shift;
  wire [4:0] pos = (wrapped >= ratio) ? wrapped - ratio : wrapped;
  wire [4:0] half = 5'((ratio + 5'h01) >> 1);
  wire last = cnt >= ratio - 5'h01;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 5'h00;
      div_out <= 1'b0;
    end else begin
      if (osc_tick) begin
        cnt <= last ? 5'h00 : cnt + 5'h01;
      end
      div_out <= (ratio == 5'h01) ? osc_level : (pos < half);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  div_wrap_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      osc_tick && last |=> cnt == 5'h00)
    else $error("divider did not wrap at its ratio");

  quad_ratio_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      (div_sel == 3'h6) && (quad_sel == 2'h2) && osc_tick && cnt == 5'h07
      |=> cnt == 5'h00)
    else $error("quadrature eight slot did not divide by eight");
endmodule

// ---- tb/pld_far_side.sv ----
// Far-side model: oscillator and reference sources for the lock detector
`timescale 1ns/10ps
module pld_far_side (
  input wire logic clk,
  input wire logic offset,
  output logic osc_in,
  output logic ref_in
);
  logic [2:0] oc;
  logic [2:0] rc;
  initial begin
    osc_in = 1'b0;
    ref_in = 1'b0;
    oc = 3'h0;
    rc = 3'h0;
  end
  // Oscillator period of eight cycles
  always @(posedge clk) begin
    oc <= (oc == 3'h3) ? 3'h0 : oc + 3'h1;
    if (oc == 3'h3) begin
      osc_in <= ~osc_in;
    end
  end
  // Aligned: reference one cycle behind; offset: period of ten cycles
  always @(posedge clk) begin
    if (!offset) begin
      ref_in <= osc_in;
      rc <= 3'h0;
    end else begin
      rc <= (rc == 3'h4) ? 3'h0 : rc + 3'h1;
      if (rc == 3'h4) begin
        ref_in <= ~ref_in;
      end
    end
  end
endmodule

// ---- tb/pll_lock_detect_divider_select_test.sv ----
// Self-checking bench for the lock detect and divider select block
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t got %h expected %h", $time, a, e); end end
module pll_lock_detect_divider_select_test
  import pld_pkg::*;
;
  logic clk, rst_n, hsel, hwrite, mode;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rd, hrdata;
  logic hreadyout, hresp, ref_in, osc_in, fb_clk, pll_lock, pump_hiz, irq;
  logic [4:0] out_clk;
  logic [3:0] pump_current_sel;
  logic [11:0] pump_current_ua;
  int miscompares, checks, p;
  int rat[8] = '{1, 2, 3, 4, 6, 8, 16, 8};
  int need[4] = '{1, 16, 64, 256};

  pld_lock_div pld_lock_div_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ref_in(ref_in), .osc_in(osc_in),
    .fb_clk(fb_clk), .out_clk(out_clk), .pll_lock(pll_lock),
    .pump_current_sel(pump_current_sel), .pump_hiz(pump_hiz),
    .pump_current_ua(pump_current_ua), .irq(irq));
  pld_far_side pld_far_side_i (.clk(clk), .offset(mode), .osc_in(osc_in), .ref_in(ref_in));

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (n > 1 && i == 599) begin
        miscompares++;
        wrap_up();
      end
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic wait_lock(input logic v, input int lim);
    int n;
    n = 0;
    while (pll_lock !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CHK(pll_lock, v)
    if (pll_lock !== v) begin
      wrap_up();
    end
  endtask
  function automatic logic sig(input int k);
    return (k == 5) ? fb_clk : out_clk[k];
  endfunction
  // Rising-to-rising distance in cycles
  task automatic period(input int k, output int q);
    int n, t;
    logic prev;
    n = 0;
    t = -1;
    q = -1;
    prev = 1'b1;
    while (q < 0) begin
      @(posedge clk);
      n++;
      if (n > 600) begin
        miscompares++;
        wrap_up();
      end
      if (!prev && sig(k) === 1'b1) begin
        if (t >= 0) q = n - t;
        t = n;
      end
      prev = sig(k);
    end
  endtask
  task automatic irqstep(input logic [7:0] a, input logic [31:0] d, input logic e);
    bus(1'b1, a, d);
    tick(3);
    `CHK(irq, e)
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    mode = 1'b0;
    miscompares = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(OFS_LOCK_CTRL, 32'h21);
    rdchk(OFS_PUMP, 32'ha);
    rdchk(OFS_FB_DIV, 32'h5);
    rdchk(OFS_OUT_DIV, 32'h5b6d);
    rdchk(OFS_WORD1_MODE, 32'h0);
    rdchk(OFS_IRQ_ENABLE, 32'h0);
    `CHK(pump_current_ua, 12'h7d0)
    `CHK(hresp, 1'b0)
    bus(1'b1, 8'h80, 32'hffffffff);
    rdchk(8'h80, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, OFS_PUMP, 32'(i));
      tick(2);
      `CHK(pump_current_sel, 4'(i))
      `CHK(pump_current_ua, 12'(i * 200))
      `CHK(pump_hiz, i == 0)
    end
    $display("test pump code done");
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, OFS_FB_DIV, 32'(c));
      bus(1'b1, OFS_OUT_DIV, {17'h0, {5{3'(c)}}});
      for (int k = 0; k < 6; k++) begin
        period(k, p);
        period(k, p);
        `CHK(p, 8 * rat[c])
      end
    end
    $display("test divider select done");
    bus(1'b1, OFS_FB_DIV, {29'h0, DIV16_CODE});
    bus(1'b1, OFS_OUT_DIV, {17'h0, {5{DIV16_CODE}}});
    for (int q = 1; q < 4; q++) begin
      bus(1'b1, OFS_WORD1_MODE, 32'(q) << 30);
      for (int k = 2; k < 6; k += 3) begin
        period(k, p);
        period(k, p);
        `CHK(p, (q == 2) ? 64 : 32)
      end
    end
    bus(1'b1, OFS_WORD1_MODE, 32'h0);
    $display("test quadrature slot done");
    bus(1'b1, OFS_FB_DIV, 32'h0);
    for (int i = 0; i < 4; i++) begin
      mode <= 1'b1;
      wait_lock(1'b0, 600);
      bus(1'b1, OFS_LOCK_CTRL, 32'((i << 4) | i));
      bus(1'b1, OFS_IRQ_CLEAR, 32'h7);
      mode <= 1'b0;
      wait_lock(1'b1, 3000);
      rdchk(OFS_STATUS, 32'((need[i] << 8) | 1));
      mode <= 1'b1;
      wait_lock(1'b0, 60);
      tick(30);
      bus(1'b0, OFS_IRQ_STATUS, 32'h0);
      `CHK(rd & 32'h6, (i == 3) ? 32'h6 : 32'h2)
    end
    $display("test lock detect done");
    bus(1'b1, OFS_LOCK_CTRL, 32'h31);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h7);
    irqstep(OFS_IRQ_ENABLE, 32'h2, 1'b0);
    mode <= 1'b0;
    wait_lock(1'b1, 3000);
    mode <= 1'b1;
    wait_lock(1'b0, 60);
    tick(3);
    `CHK(irq, 1'b1)
    irqstep(OFS_IRQ_ENABLE, 32'h0, 1'b0);
    irqstep(OFS_IRQ_ENABLE, 32'h2, 1'b1);
    irqstep(OFS_IRQ_CLEAR, 32'h2, 1'b0);
    rdchk(OFS_IRQ_CLEAR, 32'h0);
    $display("test interrupt done");
    wrap_up();
  end
endmodule
